// [logic/async_memory_bank_select.sv]
// bank select decode for the asynchronous external memory interface
`timescale 1ns/1ps
module async_memory_bank_select
  import bank_select_pkg::*;
#(
  parameter int AW = ADDR_W
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  // access request from core
  input wire access_s access_i,
  input wire logic external_port_boot_i,
  // shared pin configuration
  input wire pin_cfg_s pin2_cfg_i,
  input wire pin_cfg_s pin3_cfg_i,
  // memory pins
  output logic [AW-1:0] addr_o,
  output logic [1:0] async_bank_select_n_o,
  output logic flag2_pin_o,
  output logic flag2_pin_oe_o,
  output logic flag3_pin_o,
  output logic flag3_pin_oe_o
);
  logic [AW-1:0] addr_d;
  logic [AW-1:0] addr_q;
  logic [BANK_CNT-1:0] sel_n_d;
  logic [BANK_CNT-1:0] sel_n_q;
  logic [BANK_SEL_W-1:0] bank;

  always_comb begin
    addr_d = addr_q;
    sel_n_d = sel_n_q;
    bank = access_i.addr[BANK_SEL_LSB +: BANK_SEL_W];
    if (external_port_boot_i) begin
      bank = BOOT_BANK;
    end
    if (en_i) begin
      // condition result deliberately not an input
      if (access_i.valid) begin
        addr_d = access_i.addr;
        sel_n_d = SEL_IDLE;
        sel_n_d[bank] = 1'b0;
      end else begin
        sel_n_d = SEL_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q <= '0;
      sel_n_q <= SEL_IDLE;
    end else begin
      addr_q <= addr_d;
      sel_n_q <= sel_n_d;
    end
  end

  assign addr_o = addr_q;
  assign async_bank_select_n_o = sel_n_q[1:0];

  shared_pin_mux u_pin2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(en_i),
    .cfg_i(pin2_cfg_i),
    .bank_sel_n_i(sel_n_d[2]),
    .pin_o(flag2_pin_o),
    .pin_oe_o(flag2_pin_oe_o)
  );

  shared_pin_mux u_pin3 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(en_i),
    .cfg_i(pin3_cfg_i),
    .bank_sel_n_i(sel_n_d[3]),
    .pin_o(flag3_pin_o),
    .pin_oe_o(flag3_pin_oe_o)
  );

  // checks
  one_hot_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> $countones(~sel_n_q) <= 1)
    else $error("more than one bank select active");

  single_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && access_i.valid
    |=> $countones(~sel_n_q) == 1)
    else $error("access without exactly one select");

  idle_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && !access_i.valid
    |=> sel_n_q == SEL_IDLE)
    else $error("select active without access");

  bank_decode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && access_i.valid && !external_port_boot_i
    |=> !sel_n_q[$past(access_i.addr[BANK_SEL_LSB +: BANK_SEL_W])])
    else $error("wrong bank selected");

  addr_with_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && access_i.valid
    |=> addr_q == $past(access_i.addr))
    else $error("address and select not aligned");

  sel_with_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && access_i.valid
    |=> sel_n_q != SEL_IDLE)
    else $error("address moved without a select");

  addr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && !access_i.valid
    |=> $stable(addr_q))
    else $error("address moved while idle");

  cond_access_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && access_i.valid && access_i.cond_instr
    |=> sel_n_q != SEL_IDLE)
    else $error("conditional access dropped select");

  boot_bank_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && access_i.valid && external_port_boot_i
    |=> async_bank_select_n_o == 2'h1)
    else $error("boot access not on bank 1");

  boot_others_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && access_i.valid && external_port_boot_i
    |=> sel_n_q[0] && sel_n_q[2] && sel_n_q[3])
    else $error("boot access selected another bank");

  boot_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && access_i.valid && external_port_boot_i
    |=> addr_q == $past(access_i.addr))
    else $error("boot access lost its address");

  pin2_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && pin2_cfg_i.func == PIN_FUNC_BANK
    |=> flag2_pin_oe_o && flag2_pin_o == sel_n_q[2])
    else $error("bank 2 select not on shared pin");

  pin3_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && pin3_cfg_i.func == PIN_FUNC_BANK
    |=> flag3_pin_oe_o && flag3_pin_o == sel_n_q[3])
    else $error("bank 3 select not on shared pin");

  bank2_pin_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && access_i.valid && !external_port_boot_i && pin2_cfg_i.func == PIN_FUNC_BANK
    && access_i.addr[BANK_SEL_LSB +: BANK_SEL_W] == 2'h2 |=> !flag2_pin_o)
    else $error("bank 2 access left shared pin high");

  bank3_pin_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && access_i.valid && !external_port_boot_i && pin3_cfg_i.func == PIN_FUNC_BANK
    && access_i.addr[BANK_SEL_LSB +: BANK_SEL_W] == 2'h3 |=> !flag3_pin_o)
    else $error("bank 3 access left shared pin high");

  flag2_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && !access_i.valid && pin2_cfg_i.func == PIN_FUNC_BANK
    |=> flag2_pin_o)
    else $error("bank 2 pin low while idle");

  flag3_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && !access_i.valid && pin3_cfg_i.func == PIN_FUNC_BANK
    |=> flag3_pin_o)
    else $error("bank 3 pin low while idle");

  pin2_alt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && pin2_cfg_i.func == PIN_FUNC_ALT
    |=> flag2_pin_oe_o && flag2_pin_o == $past(pin2_cfg_i.alt_out))
    else $error("interrupt function not on pin 2");

  pin3_alt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && pin3_cfg_i.func == PIN_FUNC_ALT
    |=> flag3_pin_oe_o && flag3_pin_o == $past(pin3_cfg_i.alt_out))
    else $error("timer function not on pin 3");

  pin2_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && pin2_cfg_i.func != PIN_FUNC_ALT && pin2_cfg_i.func != PIN_FUNC_BANK
    |=> flag2_pin_o == $past(pin2_cfg_i.flag_out) && flag2_pin_oe_o == $past(pin2_cfg_i.flag_oe))
    else $error("flag function not on pin 2");

  pin3_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && pin3_cfg_i.func != PIN_FUNC_ALT && pin3_cfg_i.func != PIN_FUNC_BANK
    |=> flag3_pin_o == $past(pin3_cfg_i.flag_out) && flag3_pin_oe_o == $past(pin3_cfg_i.flag_oe))
    else $error("flag function not on pin 3");

  freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_i
    |=> $stable(sel_n_q) && $stable(addr_q))
    else $error("state changed while disabled");

  pins_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_i
    |=> $stable(flag2_pin_o) && $stable(flag2_pin_oe_o) && $stable(flag3_pin_o) && $stable(flag3_pin_oe_o))
    else $error("shared pins changed while disabled");

  bank0_c: cover property (@(posedge clk_i) disable iff (rst_i)
    !sel_n_q[0]);

  bank3_c: cover property (@(posedge clk_i) disable iff (rst_i)
    !sel_n_q[3] && flag3_pin_oe_o);

  cond_c: cover property (@(posedge clk_i) disable iff (rst_i)
    en_i && access_i.valid && access_i.cond_instr);

  boot_c: cover property (@(posedge clk_i) disable iff (rst_i)
    en_i && access_i.valid && external_port_boot_i);

  back_to_back_c: cover property (@(posedge clk_i) disable iff (rst_i)
    en_i && access_i.valid ##1 en_i && access_i.valid);
endmodule

// [logic/bank_select_pkg.sv]
// package for the asynchronous memory bank select block
package bank_select_pkg;
  localparam int ADDR_W = 32;
  localparam int BANK_CNT = 4;
  localparam int BANK_SEL_LSB = 26;
  localparam int BANK_SEL_W = 2;
  localparam logic [1:0] BOOT_BANK = 2'h1;
  localparam logic [3:0] SEL_IDLE = 4'hf;
  localparam logic [1:0] PIN_FUNC_FLAG = 2'h0;
  localparam logic [1:0] PIN_FUNC_ALT = 2'h1;
  localparam logic [1:0] PIN_FUNC_BANK = 2'h2;

  typedef struct packed {
    logic valid;
    logic cond_instr;
    logic [ADDR_W-1:0] addr;
  } access_s;

  typedef struct packed {
    logic [1:0] func;
    logic flag_out;
    logic flag_oe;
    logic alt_out;
  } pin_cfg_s;
endpackage

// [logic/shared_pin_mux.sv]
// alternate function multiplexer for one shared flag pin
`timescale 1ns/1ps
module shared_pin_mux
  import bank_select_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  // function sources
  input wire pin_cfg_s cfg_i,
  input wire logic bank_sel_n_i,
  // pin
  output logic pin_o,
  output logic pin_oe_o
);
  logic pin_d;
  logic pin_q;
  logic oe_d;
  logic oe_q;

  always_comb begin
    pin_d = pin_q;
    oe_d = oe_q;
    if (en_i) begin
      case (cfg_i.func)
        PIN_FUNC_BANK: begin
          pin_d = bank_sel_n_i;
          oe_d = 1'b1;
        end
        PIN_FUNC_ALT: begin
          pin_d = cfg_i.alt_out;
          oe_d = 1'b1;
        end
        default: begin
          pin_d = cfg_i.flag_out;
          oe_d = cfg_i.flag_oe;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      oe_q <= oe_d;
    end
  end

  assign pin_o = pin_q;
  assign pin_oe_o = oe_q;
endmodule

// [testbench/bank_memory_model.sv]
// far-side model of the external memory banks
`timescale 1ns/1ps
module bank_memory_model (
  // clock
  input wire logic clk_i,
  // selects, active low
  input wire logic [3:0] sel_n_i,
  // observed bank
  output logic [1:0] last_bank_o
);
  // remembers which bank last saw its select low
  always @(posedge clk_i) begin
    for (int k = 0; k < 4; k++) begin
      if (!sel_n_i[k]) begin
        last_bank_o <= 2'(k);
      end
    end
  end
endmodule

// [testbench/async_memory_bank_select_tb.sv]
// self-checking testbench for the bank select decode
`timescale 1ns/1ps
module async_memory_bank_select_tb;
  import bank_select_pkg::*;
  logic clk_i = 0, rst_i = 1, en_i = 0, boot = 0;
  access_s acc = '0;
  pin_cfg_s c2 = '0, c3 = '0;
  logic [31:0] a;
  logic [1:0] sel;
  logic p2, o2, p3, o3;
  logic [37:0] e, m;
  logic [1:0] mb, lb;
  logic seen = 0;
  int n_errors = 0, checks = 0;
  bank_memory_model u_mem (.clk_i(clk_i), .sel_n_i({2'b11, sel}), .last_bank_o(mb));
  async_memory_bank_select u_dut (.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i), .access_i(acc),
    .external_port_boot_i(boot), .pin2_cfg_i(c2), .pin3_cfg_i(c3), .addr_o(a),
    .async_bank_select_n_o(sel), .flag2_pin_o(p2), .flag2_pin_oe_o(o2), .flag3_pin_o(p3),
    .flag3_pin_oe_o(o3));
  always #50 clk_i = ~clk_i;
  // shared pin value and enable for one pin function
  function automatic logic [1:0] pinx(pin_cfg_s c, logic s);
    case (c.func)
      PIN_FUNC_BANK: return {s, 1'b1};
      PIN_FUNC_ALT: return {c.alt_out, 1'b1};
      default: return {c.flag_out, c.flag_oe};
    endcase
  endfunction
  // outputs expected one edge after the current inputs are taken
  function automatic logic [37:0] f(logic [37:0] old);
    logic [1:0] b;
    logic [3:0] s;
    b = boot ? BOOT_BANK : acc.addr[BANK_SEL_LSB+:BANK_SEL_W];
    s = acc.valid ? ~(4'h1 << b) : SEL_IDLE;
    return {acc.valid ? acc.addr : old[37:6], s[1:0], pinx(c2, s[2]), pinx(c3, s[3])};
  endfunction
  // far side sees the selects one edge after they are shown
  task automatic chk_mem;
    if (seen) begin
      checks++;
      if (mb !== lb) begin
        n_errors++;
        $display("MISMATCH %0t memory saw bank %h expected %h", $time, mb, lb);
      end
    end
    if (e[5:4] != 2'b11) begin
      lb = e[4] ? 2'h1 : 2'h0;
      seen = 1'b1;
    end
  endtask
  task automatic chk;
    checks++;
    if ((({a, sel, p2, o2, p3, o3} ^ e) & m) !== 38'h0) begin
      n_errors++;
      $display("MISMATCH %0t outputs %h expected %h", $time, {a, sel, p2, o2, p3, o3}, e);
    end
  endtask
  task end_of_test;
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(93567));
    e = {32'h0, 6'h3a};
    m = '1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    en_i <= 1'b1;
    @(negedge clk_i);
    chk();
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_i);
      if (en_i) begin
        e = f(e);
        m = '1;
      end
      // first accesses sit on the top edge of each bank
      acc <= {1'($urandom), 1'($urandom), i < 40 ? {4'h0, 2'(i), 26'h3ff_ffff} : 32'($urandom)};
      boot <= (i % 50) > 40;
      en_i <= (i % 7) != 3;
      c2 <= 5'($urandom);
      c3 <= 5'($urandom);
      @(negedge clk_i);
      chk();
      chk_mem();
    end
    @(posedge clk_i);
    rst_i <= 1'b1;
    e = {32'h0, 6'h3a};
    m = '1;
    @(negedge clk_i);
    chk();
    end_of_test();
  end
endmodule
